// file: core/fcb_branch_unit.sv
`default_nettype none
module fcb_branch_unit
    import fcb_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic instr_valid_i,
    input wire logic [15:0] instr_i,
    input wire logic carry_i,
    input wire logic negative_i,
    output logic [15:0] pc_o,
    output logic [1:0] q_phase_o,
    output logic busy_o,
    output logic taken_o,
    output logic flags_we_o
);
    // ************************************************
    // Phase counter and PC
    // ************************************************
    fcb_phase_t q_r, q_nxt;
    fcb_state_t st_r, st_nxt;
    logic [15:0] pc_r, pc_nxt;
    logic [15:0] instr_r, instr_nxt;
    logic take_r, take_nxt;
    logic taken_r, taken_nxt;
    logic is_br;
    logic cond;
    logic [15:0] target;

    function automatic logic [15:0] rel_target(input logic [15:0] pc, input logic [7:0] n);
        // PC has already moved past the branch word, so this is HERE + 2 + 2n
        rel_target = pc + {{7{n[7]}}, n, 1'b0};
    endfunction

    always_comb
    begin
        is_br = (instr_r[15:8] == FCB_OP_BNCC) || (instr_r[15:8] == FCB_OP_BNNC)
            || (instr_r[15:8] == FCB_OP_BNNS);
        case (instr_r[15:8])
            FCB_OP_BNCC: cond = !carry_i;
            FCB_OP_BNNC: cond = !negative_i;
            FCB_OP_BNNS: cond = negative_i;
            default: cond = 1'b0;
        endcase
        target = rel_target(pc_r, instr_r[7:0]);
        q_nxt = fcb_phase_t'(q_r + 2'd1);
        st_nxt = st_r;
        pc_nxt = pc_r;
        instr_nxt = instr_r;
        take_nxt = take_r;
        taken_nxt = taken_r;
        case (q_r)
            FCB_Q1:
            begin
                taken_nxt = 1'b0;
                if (st_r == FCB_EXEC)
                begin
                    // Decode: latch word and step PC past it
                    instr_nxt = instr_valid_i ? instr_i : 16'h0000;
                    if (instr_valid_i)
                    begin
                        pc_nxt = pc_r + FCB_WORD_STEP;
                    end
                end
            end
            FCB_Q2: take_nxt = 1'b0;
            FCB_Q3: take_nxt = (st_r == FCB_EXEC) && is_br && cond;
            FCB_Q4:
            begin
                if (st_r == FCB_FLUSH)
                begin
                    st_nxt = FCB_EXEC;
                end
                else if (take_r)
                begin
                    pc_nxt = target;
                    taken_nxt = 1'b1;
                    st_nxt = FCB_FLUSH;
                end
                // Untaken: PC keeps the sequential address
            end
            default: q_nxt = FCB_Q1;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            q_r <= FCB_Q1;
            st_r <= FCB_EXEC;
            pc_r <= FCB_PC_RESET;
            instr_r <= 16'h0000;
            take_r <= 1'b0;
            taken_r <= 1'b0;
        end
        else
        begin
            q_r <= q_nxt;
            st_r <= st_nxt;
            pc_r <= pc_nxt;
            instr_r <= instr_nxt;
            take_r <= take_nxt;
            taken_r <= taken_nxt;
        end
    end

    assign pc_o = pc_r;
    assign q_phase_o = q_r;
    assign busy_o = (st_r == FCB_FLUSH);
    assign taken_o = taken_r;
    assign flags_we_o = 1'b0;

    // ************************************************
    // Check helpers
    // ************************************************
    // Address of the word taken in Q1, so the checks can rebuild its target
    // without leaning on the target adder they are meant to judge
    logic [15:0] here_r, here_nxt;

    always_comb
    begin
        here_nxt = here_r;
        if (q_r == FCB_Q1 && st_r == FCB_EXEC && instr_valid_i)
        begin
            here_nxt = pc_r;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            here_r <= FCB_PC_RESET;
        end
        else
        begin
            here_r <= here_nxt;
        end
    end

    // ************************************************
    // Checks
    // ************************************************
    chk_taken_pc_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (q_r == FCB_Q4 && st_r == FCB_EXEC && take_r) |=> (pc_r == $past(target) && busy_o))
        else $error("taken branch did not load target");
    chk_untaken_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (q_r == FCB_Q4 && !take_r) |=> $stable(pc_r))
        else $error("untaken branch wrote PC");
    chk_flush_len: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(busy_o) |-> busy_o [*4] ##1 !busy_o)
        else $error("flush cycle length wrong");
    chk_flush_pc: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (busy_o && q_r != FCB_Q4) |=> $stable(pc_r))
        else $error("PC moved in idle cycle");
    chk_carry_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (q_r == FCB_Q3 && !busy_o && instr_r[15:8] == FCB_OP_BNCC) |=> (take_r == !$past(carry_i)))
        else $error("carry clear decision wrong");
    chk_neg_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (q_r == FCB_Q3 && !busy_o && instr_r[15:8] == FCB_OP_BNNC)
        |=> (take_r == !$past(negative_i)))
        else $error("negative clear decision wrong");
    chk_neg_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (q_r == FCB_Q3 && !busy_o && instr_r[15:8] == FCB_OP_BNNS)
        |=> (take_r == $past(negative_i)))
        else $error("negative set decision wrong");
    chk_pc_step: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (q_r == FCB_Q1 && !busy_o && instr_valid_i) |=> (pc_r == $past(pc_r) + FCB_WORD_STEP))
        else $error("PC not advanced past word");
    // Target rebuilt from the branch word's own address
    chk_target_math: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (q_r == FCB_Q4 && st_r == FCB_EXEC && take_r)
        |=> (pc_r == here_r + FCB_WORD_STEP + {{7{instr_r[7]}}, instr_r[7:0], 1'b0}))
        else $error("target offset wrong");
    chk_flags_kept: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !flags_we_o)
        else $error("flags written");

    // ************************************************
    // Sequencing checks
    // ************************************************
    chk_phase_wrap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (q_r == FCB_Q4) |=> (q_r == FCB_Q1))
        else $error("phase did not wrap to Q1");
    chk_phase_step: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (q_r != FCB_Q4) |=> (q_r == fcb_phase_t'($past(q_r) + 2'd1)))
        else $error("phase did not advance");
    chk_pc_quiet: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (q_r == FCB_Q2 || q_r == FCB_Q3) |=> $stable(pc_r))
        else $error("PC written in Q2 or Q3");
    chk_take_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (q_r == FCB_Q2) |=> !take_r)
        else $error("stale branch decision");
    // The idle second cycle of a taken branch neither decides nor moves the PC
    chk_idle_no_decide: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (busy_o && q_r == FCB_Q3) |=> !take_r)
        else $error("decision made in idle cycle");
    chk_taken_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(taken_o) |=> !taken_o)
        else $error("taken flag held too long");
    chk_busy_taken: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(busy_o) |-> taken_o)
        else $error("idle cycle without taken branch");
    chk_busy_refuse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (busy_o && q_r == FCB_Q1) |=> ($stable(instr_r) && $stable(pc_r)))
        else $error("word accepted in idle cycle");
    chk_untaken_free: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (q_r == FCB_Q4 && st_r == FCB_EXEC && !take_r) |=> (!busy_o && !taken_o))
        else $error("untaken branch added a cycle");
    chk_untaken_pc: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (q_r == FCB_Q4 && st_r == FCB_EXEC && !take_r && is_br)
        |=> (pc_r == here_r + FCB_WORD_STEP))
        else $error("untaken branch left wrong PC");
    chk_other_ops: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (q_r == FCB_Q3 && !busy_o && instr_r[15:8] != FCB_OP_BNCC
        && instr_r[15:8] != FCB_OP_BNNC && instr_r[15:8] != FCB_OP_BNNS) |=> !take_r)
        else $error("non-branch word took a branch");
    chk_word_latch: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (q_r == FCB_Q1 && !busy_o && instr_valid_i) |=> (instr_r == $past(instr_i)))
        else $error("word not latched in Q1");
endmodule
`default_nettype wire

// file: core/fcb_pkg.sv
`default_nettype none
package fcb_pkg;
    localparam logic [7:0] FCB_OP_BNCC = 8'h0E3;
    localparam logic [7:0] FCB_OP_BNNC = 8'h0E7;
    localparam logic [7:0] FCB_OP_BNNS = 8'h0E6;
    localparam logic [15:0] FCB_PC_RESET = 16'h0000;
    localparam logic [15:0] FCB_WORD_STEP = 16'h0002;
    localparam logic [1:0] FCB_Q_RESET = 2'h0;

    typedef enum logic [1:0] {
        FCB_Q1 = 2'b00,
        FCB_Q2 = 2'b01,
        FCB_Q3 = 2'b10,
        FCB_Q4 = 2'b11
    } fcb_phase_t;

    typedef enum logic [0:0] {
        FCB_EXEC = 1'b0,
        FCB_FLUSH = 1'b1
    } fcb_state_t;
endpackage
`default_nettype wire

// file: verification/fcb_fetch_model.sv
`default_nettype none
// ****************
// Fetch side model
// ****************
module fcb_fetch_model (
    input wire logic go_i,
    input wire logic [15:0] word_i,
    output logic instr_valid_o,
    output logic [15:0] instr_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Released bus shows the inverse of the last word
    assign instr_valid_o = go_i;
    assign instr_o = go_i ? word_i : ~word_i;
endmodule
`default_nettype wire

// file: verification/tb_flag_conditional_branch_unit.sv
`default_nettype none
module tb_flag_conditional_branch_unit
    import fcb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 0, rst_n_i = 0, go = 0, carry = 0, neg = 0, valid;
    logic [15:0] word = 16'h0000, instr, pc_o;
    logic [1:0] q_phase_o;
    logic busy_o, taken_o, flags_we_o;
    int n_errors = 0, compares = 0, cycles = 0;

    initial forever #2.5 clk_i = ~clk_i;
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            n_errors++;
            results();
        end
    end

    fcb_branch_unit DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .instr_valid_i(valid),
        .instr_i(instr), .carry_i(carry), .negative_i(neg), .pc_o(pc_o),
        .q_phase_o(q_phase_o), .busy_o(busy_o), .taken_o(taken_o),
        .flags_we_o(flags_we_o));
    fcb_fetch_model fetch (.go_i(go), .word_i(word), .instr_valid_o(valid), .instr_o(instr));

    // ***********
    // Bench tasks
    // ***********
    task check(string what, logic [15:0] seen, logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task step(int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask

    task run(logic [7:0] op, logic [7:0] n, logic c, logic ng, logic tk);
        logic [15:0] here;
        logic [15:0] dest;
        int w;
        w = 0;
        while (!(q_phase_o === 2'h0 && busy_o === 1'b0) && w < 20)
        begin
            step(1);
            w++;
        end
        here = pc_o;
        dest = here + 16'h0002 + (tk ? {{7{n[7]}}, n, 1'b0} : 16'h0000);
        word = {op, n};
        carry = c;
        neg = ng;
        go = 1;
        step(1);
        go = 0;
        check("pc_next", pc_o, here + 16'h0002);
        check("phase", {14'h0, q_phase_o}, {14'h0, FCB_Q2});
        step(2);
        check("pc_before_q4", pc_o, here + 16'h0002);
        step(1);
        check("pc", pc_o, dest);
        check("taken", {15'h0000, taken_o}, {15'h0000, tk});
        check("busy", {15'h0000, busy_o}, {15'h0000, tk});
        check("flags_we", {15'h0000, flags_we_o}, 16'h0000);
        step(1);
        check("taken_end", {15'h0000, taken_o}, 16'h0000);
        step(2);
        check("busy_hold", {15'h0000, busy_o}, {15'h0000, tk});
        check("pc_idle", pc_o, dest);
        step(1);
        check("busy_end", {15'h0000, busy_o}, 16'h0000);
        check("phase_end", {14'h0, q_phase_o}, {14'h0, FCB_Q1});
    endtask

    task t_carry_clear;
        run(FCB_OP_BNCC, 8'h7F, 0, 1, 1);
        run(FCB_OP_BNCC, 8'h7F, 1, 0, 0);
        $display("test carry_clear done");
    endtask

    task t_neg_clear;
        run(FCB_OP_BNNC, 8'h80, 1, 0, 1);
        run(FCB_OP_BNNC, 8'h80, 0, 1, 0);
        $display("test negative_clear done");
    endtask

    task t_neg_set;
        run(FCB_OP_BNNS, 8'hFF, 0, 1, 1);
        run(FCB_OP_BNNS, 8'hFF, 1, 0, 0);
        run(8'h00, 8'h10, 0, 0, 0);
        $display("test negative_set done");
    endtask

    task t_reset;
        word = {FCB_OP_BNCC, 8'h10};
        carry = 0;
        go = 1;
        step(1);
        go = 0;
        step(3);
        check("busy_pre", {15'h0000, busy_o}, 16'h0001);
        rst_n_i = 0;
        step(2);
        check("pc_reset", pc_o, FCB_PC_RESET);
        check("phase_reset", {14'h0, q_phase_o}, {14'h0, FCB_Q_RESET});
        check("busy_reset", {15'h0000, busy_o}, 16'h0000);
        check("taken_reset", {15'h0000, taken_o}, 16'h0000);
        rst_n_i = 1;
        run(FCB_OP_BNNC, 8'h03, 0, 0, 1);
        $display("test reset done");
    endtask

    task results;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        step(10);
        rst_n_i = 1;
        t_carry_clear();
        t_neg_clear();
        t_neg_set();
        t_reset();
        results();
    end
endmodule
`default_nettype wire
